// file: verilog/i2c_host_map.svh
// constants for the control bus host
// How it works
// - host acknowledges read bytes wanting more
// - host ends read with not_acknowledge_bit, stop
// - transactions open start, close stop
// - host waits while scl held low
// - sending one, seeing zero loses arbitration
// - loser releases sda, retries when idle
// - remote access one direction at once
// - no repeated start during other's bit
// - no stop during other's bit
// - one channel direction active at once
// - mailbox register may pass channel control
`ifndef I2C_HOST_MAP_SVH
`define I2C_HOST_MAP_SVH
`define ADDR_BASE 7'h0c
`define ADDR_STEP 7'h02
`define MAILBOX_A 8'h18
`define MAILBOX_B 8'h19
`define QTR_NS 2500
`define CLK_NS 25
`define QTR_CYC ((`QTR_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// file: verilog/i2c_host_pkg.sv
// types for the control bus host
package i2c_host_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_START, ST_BIT, ST_ACK, ST_STOP, ST_WAIT_IDLE
   } phase_t;
   typedef struct packed {
      logic [1:0] rst_sync;
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic sda_prev;
      logic scl_prev;
      logic bus_busy;
      phase_t phase;
      logic [1:0] quarter;
      logic [7:0] cnt;
      logic [3:0] bitn;
      logic [7:0] shift;
      logic [1:0] byte_idx;
      logic rnw;
      logic last;
      logic [7:0] rdata;
      logic scl_oe_n;
      logic sda_oe_n;
      logic done;
      logic ack_ok;
      logic lost;
      logic busy;
      logic [7:0] rdata_o;
   } host_st_t;
endpackage : i2c_host_pkg

// file: verilog/i2c_host.sv
// i2c master that writes or reads one register of the serializer
`timescale 1ns/1ps
`default_nettype none
`include "i2c_host_map.svh"
module i2c_host (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // command port
   input wire logic go,
   input wire logic rnw,
   input wire logic [2:0] strap_level,
   input wire logic use_reg_addr,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] offset,
   input wire logic [7:0] wdata,
   output logic busy,
   output logic done,
   output logic ack_ok,
   output logic lost,
   output logic [7:0] rdata,
   // bus pins, open drain
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);
   i2c_host_pkg::host_st_t q, d;
   logic rst_l;
   logic [6:0] target;
   logic [7:0] cur_byte;
   logic scl_hi, sda_hi, stall, tick;

   assign rst_l = q.rst_sync[1];
   // strap level maps to even addresses in steps of two
   assign target = use_reg_addr ? reg_addr :
      (`ADDR_BASE + 7'(`ADDR_STEP * strap_level));
   assign scl_hi = q.scl_s[1];
   assign sda_hi = q.sda_s[1];
   // released clock still low: a stretch, so the quarter end is held
   assign stall = q.scl_oe_n && !scl_hi;
   assign tick = (q.cnt == 8'(`QTR_CYC - 1)) && !stall;

   always_comb
   begin
      d = q;
      d.rst_sync = {q.rst_sync[0], 1'b1};
      d.scl_s = {q.scl_s[0], scl_i};
      d.sda_s = {q.sda_s[0], sda_i};
      d.scl_prev = scl_hi;
      d.sda_prev = sda_hi;
      d.done = 1'b0;
      // every start and stop tracked, own ones too, so a retry waits for a stop
      if (scl_hi && q.scl_prev && q.sda_prev && !sda_hi)
         d.bus_busy = 1'b1;
      if (scl_hi && q.scl_prev && !q.sda_prev && sda_hi)
         d.bus_busy = 1'b0;
      unique case (q.byte_idx)
         2'd0: cur_byte = {target, 1'b0};
         2'd1: cur_byte = offset;
         2'd2: cur_byte = q.rnw ? {target, 1'b1} : wdata;
         default: cur_byte = 8'hff;
      endcase
      // start, bit, ack and stop actions run once per quarter, never again while stretched
      if (tick)
         d.cnt = 8'h00;
      else if (q.cnt != 8'(`QTR_CYC - 1))
         d.cnt = q.cnt + 8'h01;
      if (tick)
         d.quarter = q.quarter + 2'd1;
      unique case (q.phase)
         i2c_host_pkg::ST_IDLE:
         begin
            d.scl_oe_n = 1'b1;
            d.sda_oe_n = 1'b1;
            if (go && !q.bus_busy && scl_hi && sda_hi)
            begin
               d.rnw = rnw;
               d.byte_idx = 2'd0;
               d.busy = 1'b1;
               d.lost = 1'b0;
               d.ack_ok = 1'b1;
               d.quarter = 2'd0;
               d.cnt = 8'h00;
               d.phase = i2c_host_pkg::ST_START;
            end
         end
         i2c_host_pkg::ST_START:
            if (tick)
            begin
               unique case (q.quarter)
                  2'd0: d.sda_oe_n = 1'b1;
                  2'd1: d.scl_oe_n = 1'b1;
                  2'd2: d.sda_oe_n = 1'b0;
                  default:
                  begin
                     d.scl_oe_n = 1'b0;
                     d.bitn = 4'd7;
                     d.phase = i2c_host_pkg::ST_BIT;
                  end
               endcase
            end
         i2c_host_pkg::ST_BIT:
            if (tick)
            begin
               unique case (q.quarter)
                  2'd0: d.sda_oe_n = (q.rnw && q.byte_idx == 2'd3) ? 1'b1
                     : cur_byte[q.bitn[2:0]];
                  2'd1: d.scl_oe_n = 1'b1;
                  2'd2:
                  begin
                     if (!q.sda_oe_n == 1'b0 && q.sda_oe_n && !sda_hi
                        && !(q.rnw && q.byte_idx == 2'd3))
                     begin
                        // release both lines at once, retry later
                        d.lost = 1'b1;
                        d.sda_oe_n = 1'b1;
                        d.scl_oe_n = 1'b1;
                        d.phase = i2c_host_pkg::ST_WAIT_IDLE;
                     end
                     d.rdata = {q.rdata[6:0], sda_hi};
                  end
                  default:
                  begin
                     d.scl_oe_n = 1'b0;
                     if (q.bitn == 4'd0)
                        d.phase = i2c_host_pkg::ST_ACK;
                     else
                        d.bitn = q.bitn - 4'd1;
                  end
               endcase
            end
         i2c_host_pkg::ST_ACK:
            if (tick)
            begin
               unique case (q.quarter)
                  // read data: ack only when more wanted, one byte so not_acknowledge_bit
                  2'd0: d.sda_oe_n = 1'b1;
                  2'd1: d.scl_oe_n = 1'b1;
                  2'd2:
                     if (!(q.rnw && q.byte_idx == 2'd3) && sda_hi)
                        d.ack_ok = 1'b0;
                  default:
                  begin
                     d.scl_oe_n = 1'b0;
                     d.bitn = 4'd7;
                     if (!q.ack_ok || (sda_hi && !(q.rnw && q.byte_idx == 2'd3))
                        || q.byte_idx == 2'd3 || (!q.rnw && q.byte_idx == 2'd2))
                        d.phase = i2c_host_pkg::ST_STOP;
                     else if (q.rnw && q.byte_idx == 2'd1)
                     begin
                        d.byte_idx = 2'd2;
                        d.phase = i2c_host_pkg::ST_START;
                     end
                     else
                     begin
                        d.byte_idx = q.byte_idx + 2'd1;
                        d.phase = i2c_host_pkg::ST_BIT;
                     end
                     if (q.byte_idx == 2'd2 && q.rnw && q.ack_ok && !sda_hi)
                     begin
                        d.byte_idx = 2'd3;
                        d.phase = i2c_host_pkg::ST_BIT;
                     end
                  end
               endcase
            end
         i2c_host_pkg::ST_STOP:
            if (tick)
            begin
               unique case (q.quarter)
                  2'd0: d.sda_oe_n = 1'b0;
                  2'd1: d.scl_oe_n = 1'b1;
                  2'd2: d.sda_oe_n = 1'b1;
                  default:
                  begin
                     d.busy = 1'b0;
                     d.done = 1'b1;
                     d.rdata_o = q.rdata;
                     d.phase = i2c_host_pkg::ST_IDLE;
                  end
               endcase
            end
         i2c_host_pkg::ST_WAIT_IDLE:
         begin
            d.scl_oe_n = 1'b1;
            d.sda_oe_n = 1'b1;
            // retry the whole transaction once another master stops
            if (!q.bus_busy && scl_hi && sda_hi)
            begin
               d.quarter = 2'd0;
               d.cnt = 8'h00;
               d.byte_idx = 2'd0;
               d.phase = i2c_host_pkg::ST_START;
            end
         end
         default: d.phase = i2c_host_pkg::ST_IDLE;
      endcase
      if (!rst_l)
      begin
         d = '0;
         d.rst_sync = {q.rst_sync[0], 1'b1};
         d.scl_s = 2'b11;
         d.sda_s = 2'b11;
         d.scl_prev = 1'b1;
         d.sda_prev = 1'b1;
         d.scl_oe_n = 1'b1;
         d.sda_oe_n = 1'b1;
         d.phase = i2c_host_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.scl_s <= 2'b11;
         q.sda_s <= 2'b11;
         q.scl_prev <= 1'b1;
         q.sda_prev <= 1'b1;
         q.scl_oe_n <= 1'b1;
         q.sda_oe_n <= 1'b1;
      end
      else
         q <= d;
   end

   // output data tied low: the line is only ever pulled low or released
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_n = q.scl_oe_n;
   assign sda_oe_n = q.sda_oe_n;
   assign busy = q.busy;
   assign done = q.done;
   assign ack_ok = q.ack_ok;
   assign lost = q.lost;
   assign rdata = q.rdata_o;
endmodule : i2c_host
`default_nettype wire

// file: verification/i2c_host_props.sv
// assertions on the control bus host ports
`timescale 1ns/1ps
`default_nettype none
module i2c_host_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // command side
   input wire logic go,
   input wire logic busy,
   input wire logic done,
   input wire logic ack_ok,
   input wire logic [7:0] rdata,
   // bus pins
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe_n,
   input wire logic sda_o,
   input wire logic sda_oe_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_never_high: assert property (!scl_o && !sda_o)
      else $error("pin driven high");
   a_start_cond: assert property ($fell(sda_oe_n) && scl_oe_n |-> scl_i)
      else $error("data pulled while clock line low");
   a_stop_cond: assert property ($rose(sda_oe_n) && scl_oe_n |-> scl_i)
      else $error("data released while clock line low");
   a_stretch_wait: assert property (busy && scl_oe_n && !scl_i |=> scl_oe_n)
      else $error("clock pulled during stretch");
   a_busy_go: assert property ($rose(busy) |-> $past(go))
      else $error("busy without go");
   a_done_pulse: assert property (done |-> $past(busy) ##1 !done)
      else $error("done not a single pulse");
   a_result_stand: assert property ($changed(rdata) || $changed(ack_ok) |-> busy || done)
      else $error("result changed while idle");
   a_idle_free: assert property (!busy && !$past(busy) && !done |-> scl_oe_n && sda_oe_n)
      else $error("line held while idle");
endmodule : i2c_host_chk
bind i2c_host i2c_host_chk i_i2c_host_chk (.mclk, .rst_n, .go, .busy, .done, .ack_ok, .rdata,
   .scl_i, .scl_o, .scl_oe_n, .sda_o, .sda_oe_n);
`default_nettype wire

// file: verification/ser_ctl_target.sv
// behavioural serializer target on the control bus
`timescale 1ns/1ps
`default_nettype none
module ser_ctl_target #(
   parameter logic [2:0] STRAP = 3'h3,
   parameter int STRETCH_NS = 12000
) (
   // wire levels
   input wire logic scl,
   input wire logic sda,
   // pulls, high means pull low
   output logic scl_pull,
   output logic sda_pull
);
   logic [7:0] mem [0:255];
   logic [7:0] sh, ptr, dout;
   logic act, hit, rd, tx;
   int bitc, byt;
   // one of eight even addresses, or the stored one
   wire logic [6:0] own = mem[0][0] ? mem[0][7:1] : 7'h0c + {3'h0, STRAP, 1'b0};
   initial
   begin
      {scl_pull, sda_pull, act, hit, rd, tx, ptr, sh, dout} = '0;
      bitc = 0;
      byt = 0;
      foreach (mem[i]) mem[i] = 8'h00;
      mem[0] = {7'h0c + {3'h0, STRAP, 1'b0}, 1'b0};
   end
   always @(negedge sda) if (scl) {act, tx, bitc, byt} = {2'b10, 32'd0, 32'd0};
   always @(posedge sda) if (scl) {act, tx, sda_pull} = 3'b000;
   // one shared store: a byte lands whole, never torn
   always @(posedge scl) if (act)
   begin
      if (bitc < 8) sh = {sh[6:0], sda};
      bitc++;
      if (bitc == 8 && !tx)
      begin
         if (byt == 0) {hit, rd} = {sh[7:1] == own, sh[0]};
         else if (hit && byt == 1) ptr = sh;
         else if (hit) mem[ptr++] = sh;
      end
      if (bitc == 9)
      begin
         if (tx) ptr++;
         if (tx && sda) act = 0;
         tx = hit && rd && act;
         dout = mem[ptr];
         bitc = 0;
         byt++;
      end
   end
   // addressed: stretch past the host's sample point so the host must wait
   always @(negedge scl) if (act)
   begin
      if (tx && bitc < 8) sda_pull = !dout[7 - bitc];
      else sda_pull = bitc == 8 && hit && !tx;
      if (bitc == 8 && hit)
      begin
         scl_pull = 1'b1;
         #(STRETCH_NS) scl_pull = 1'b0;
      end
   end
endmodule : ser_ctl_target
`default_nettype wire

// file: verification/tb_i2c_host.sv
// self-checking bench for the control bus host
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_host;
   typedef struct packed {
      logic rd, ureg;
      logic [6:0] ra;
      logic [7:0] off, wd, ack, rdat;
   } row_t;
   logic mclk, rst_n, go, rnw, use_reg_addr, busy, done, ack_ok, lost;
   logic scl_o, scl_oe_n, sda_o, sda_oe_n, scl_pull, sda_pull, rival_pull;
   logic [2:0] strap_level;
   logic [6:0] reg_addr;
   logic [7:0] offset, wdata, rdata;
   int errors = 0;
   int total_checks = 0;
   int waits;
   // open drain wires with pull-ups
   wire logic scl_w = !(!scl_oe_n || scl_pull);
   // a second master pulls data through rival_pull
   wire logic sda_w = !(!sda_oe_n || sda_pull || rival_pull);
   // row 3 moves the target to 0x1c, so row 4 is refused and row 5 reaches it there
   localparam row_t rows [5] = '{
      '{1'b0, 1'b0, 7'h00, 8'h18, 8'ha5, 8'h01, 8'h00},
      '{1'b1, 1'b0, 7'h00, 8'h18, 8'h00, 8'h01, 8'ha5},
      '{1'b0, 1'b0, 7'h00, 8'h00, 8'h39, 8'h01, 8'h00},
      '{1'b0, 1'b0, 7'h00, 8'h18, 8'h11, 8'h00, 8'h00},
      '{1'b1, 1'b1, 7'h1c, 8'h18, 8'h00, 8'h01, 8'ha5}};
   i2c_host i_i2c_host (.mclk(mclk), .rst_n(rst_n), .go(go), .rnw(rnw),
      .strap_level(strap_level), .use_reg_addr(use_reg_addr), .reg_addr(reg_addr),
      .offset(offset), .wdata(wdata), .busy(busy), .done(done), .ack_ok(ack_ok),
      .lost(lost), .rdata(rdata), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
   ser_ctl_target #(.STRAP(3'h3)) i_ser_ctl_target (.scl(scl_w), .sda(sda_w),
      .scl_pull(scl_pull), .sda_pull(sda_pull));
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : finish_test
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         errors++;
      end
   endtask : chk
   task automatic run(input row_t r);
      @(negedge mclk);
      {rnw, use_reg_addr, reg_addr, offset, wdata, go} = {r.rd, r.ureg, r.ra, r.off, r.wd, 1'b1};
      @(negedge mclk);
      go = 1'b0;
      wait_done();
   endtask : run
   task automatic wait_done;
      int n;
      n = 0;
      while (done !== 1'b1 && n < 30000)
      begin
         @(negedge mclk);
         n++;
      end
      if (n == 30000) chk("done", 8'h01, 8'h00);
      if (n == 30000) finish_test();
   endtask : wait_done
   initial
   begin
      {rst_n, go, rnw, use_reg_addr, reg_addr, offset, wdata, rival_pull} = '0;
      strap_level = 3'h3;
      repeat (8) @(negedge mclk);
      chk("reset lines", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
      rst_n = 1'b1;
      repeat (10) @(negedge mclk);
      foreach (rows[i])
      begin
         run(rows[i]);
         chk("ack_ok", rows[i].ack, {7'h00, ack_ok});
         chk("lost", 8'h00, {7'h00, lost});
         if (rows[i].rd) chk("rdata", rows[i].rdat, rdata);
         $display("test %0d done", i);
      end
      // a rival holds data low from our start, so our first one bit loses
      @(negedge mclk);
      {rnw, use_reg_addr, reg_addr, offset, wdata, go} = {1'b0, 1'b1, 7'h1c, 8'h19, 8'h5a, 1'b1};
      @(negedge mclk);
      {go, rival_pull} = 2'b01;
      waits = 0;
      while (lost !== 1'b1 && waits < 3000)
      begin
         @(negedge mclk);
         waits++;
      end
      chk("lost", 8'h01, {7'h00, lost});
      if (waits == 3000) finish_test();
      chk("released", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
      repeat (200) @(negedge mclk);
      chk("wait busy", 8'h03, {6'h00, busy, sda_oe_n});
      // rival lets go with the clock high: a stop, then the whole write again
      rival_pull = 1'b0;
      wait_done();
      chk("retry ack_ok", 8'h01, {7'h00, ack_ok});
      chk("retry lost", 8'h01, {7'h00, lost});
      $display("test arbitration done");
      // abort in mid transfer: lines must be let go at once
      @(negedge mclk);
      {rnw, use_reg_addr, reg_addr, go} = {1'b0, 1'b1, 7'h1c, 1'b1};
      @(negedge mclk);
      go = 1'b0;
      repeat (1000) @(negedge mclk);
      chk("busy", 8'h01, {7'h00, busy});
      rst_n = 1'b0;
      @(negedge mclk);
      chk("abort", 8'h03, {5'h00, busy, scl_oe_n, sda_oe_n});
      $display("test abort done");
      // second release of reset: the retried write must read back
      rst_n = 1'b1;
      repeat (10) @(negedge mclk);
      run('{1'b1, 1'b1, 7'h1c, 8'h19, 8'h00, 8'h01, 8'h5a});
      chk("reset ack_ok", 8'h01, {7'h00, ack_ok});
      chk("reset lost", 8'h00, {7'h00, lost});
      chk("reset rdata", 8'h5a, rdata);
      $display("test reset release done");
      finish_test();
   end
endmodule : tb_i2c_host
`default_nettype wire
